// ### rtl/pmrsc_ctrl.sv
// pmrsc_ctrl: power-mode controller for register retention, standby and active
`timescale 1ns/10ps
`default_nettype none

// Operation
// - short pre-start on tick wake when allowed
// - no short pre-start if crystal not running
// - retention wakeup resumes, never resets system
// - standby also wakes on radio, misc irq
// - comparator ignored while in standby
// - standby stops cpu clock, resumes ~100 ns
// - standby keeps memories, regulator, crystal powered
// - code 100 to power-down register enters retention
// - active low-freq source selects timers-on retention
// - active mode powers memories, regulator, io, cpu clocked; oscillators follow start field
// - timers-on retention wakes on pin, tick, comparator
// - status bit shows crystal or rc system clock
module pmrsc_ctrl
  import pmrsc_pkg::*;
#(
  parameter int LONG_PRE_CYC  = PMRSC_LONG_PRE_CYC,
  parameter int SHORT_PRE_CYC = PMRSC_SHORT_PRE_CYC,
  parameter int SBY_WAKE_CYC  = PMRSC_SBY_WAKE_CYC
)(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_I,
  // wishbone classic slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [11:0] ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  // wakeup sources and oscillator status
  input  wire logic        WAKE_PIN_I,
  input  wire logic        TIMER_TICK_I,
  input  wire logic        COMP_WAKE_I,
  input  wire logic        RADIO_IRQ_I,
  input  wire logic        MISC_IRQ_B_I,
  input  wire logic        CRYSTAL_OSC_16M_RUN_I,
  input  wire logic        LOW_FREQ_CLOCK_I,
  input  wire logic        LOW_FREQ_CLOCK_RDY_I,
  // power and clock controls
  output logic             CPU_CLK_EN_O,
  output logic             SYS_RESET_O,
  output logic             PROG_MEM_PWR_O,
  output logic             DATA_MEM_PWR_O,
  output logic             VOLTAGE_REGULATOR_EN_O,
  output logic             CRYSTAL_OSC_16M_EN_O,
  output logic             RC_OSC_16M_A_EN_O,
  output logic             LF_TIMERS_EN_O,
  output logic             IO_ACTIVE_O,
  output logic [1:0]       MODE_O,
  output logic             IRQ_O
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       req;
  logic       wr_acc;
  logic       rd_acc;
  logic [9:0] idx;
  logic       lane0;

  assign req    = CYC_I && STB_I && !ACK_O;
  assign idx    = ADR_I[11:2];
  assign lane0  = SEL_I[0];
  assign wr_acc = req && WE_I && lane0;
  assign rd_acc = req && !WE_I;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]   clock_control_reg_q;
  logic [2:0]   lf_sel_q;
  logic [2:0]   wake_flags_q;
  logic [3:0]   irq_stat_q;
  logic [3:0]   irq_mask_q;
  pmrsc_state_t state_q;
  logic         timers_on_q;
  logic         short_ok_q;
  logic         xosc_run_q;

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      clock_control_reg_q <= PMRSC_CLOCK_CONTROL_REG_RST;
      lf_sel_q            <= PMRSC_LFSEL_RST;
      irq_mask_q          <= PMRSC_IRQ_RST;
    end
    else if (wr_acc)
    begin
      if (idx == PMRSC_IDX_CLOCK_CONTROL_REG)
        clock_control_reg_q <= DAT_I[7:0];
      if (idx == PMRSC_IDX_LFSEL)
        lf_sel_q <= DAT_I[2:0];
      if (idx == PMRSC_IDX_IRQ_MASK)
        irq_mask_q <= DAT_I[3:0];
    end
  end

  // ----------------------------------------------------------------
  // power-down request
  // ----------------------------------------------------------------
  logic pd_ret_req;
  logic pd_sby_req;

  // only accepted from active: the cpu is the sole writer of the code
  assign pd_ret_req = wr_acc && idx == PMRSC_IDX_POWER_DOWN_REG && state_q == PMRSC_ST_ACTIVE
                      && DAT_I[2:0] == PMRSC_PD_REG_RET;
  assign pd_sby_req = wr_acc && idx == PMRSC_IDX_POWER_DOWN_REG && state_q == PMRSC_ST_ACTIVE
                      && DAT_I[2:0] == PMRSC_PD_STANDBY;

  // ----------------------------------------------------------------
  // wakeup qualification
  // ----------------------------------------------------------------
  logic ret_pin;
  logic ret_tick;
  logic ret_comp;
  logic ret_wake;
  logic sby_wake;
  logic tick_short;

  assign ret_pin  = state_q == PMRSC_ST_RETAIN && WAKE_PIN_I;
  assign ret_tick = state_q == PMRSC_ST_RETAIN && timers_on_q && TIMER_TICK_I;
  assign ret_comp = state_q == PMRSC_ST_RETAIN && timers_on_q && COMP_WAKE_I;
  assign ret_wake = ret_pin || ret_tick || ret_comp;

  // comparator deliberately absent from the standby set
  assign sby_wake = state_q == PMRSC_ST_STANDBY
                    && (WAKE_PIN_I || TIMER_TICK_I
                        || RADIO_IRQ_I || MISC_IRQ_B_I);

  // pin wins over tick when both arrive, so the long start-up applies
  assign tick_short = ret_tick && !ret_pin && short_ok_q;

  // ----------------------------------------------------------------
  // start-up delay
  // ----------------------------------------------------------------
  logic                   wait_load;
  logic [PMRSC_CNT_W-1:0] wait_cnt;
  logic                   wait_done;

  assign wait_load = ret_wake || sby_wake;

  always_comb
  begin
    if (sby_wake)
      wait_cnt = PMRSC_CNT_W'(SBY_WAKE_CYC);
    else if (tick_short)
      wait_cnt = PMRSC_CNT_W'(SHORT_PRE_CYC);
    else
      wait_cnt = PMRSC_CNT_W'(LONG_PRE_CYC);
  end

  pmrsc_wait #(
    .W (PMRSC_CNT_W)
  ) u_wait (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .load_i  (wait_load),
    .count_i (wait_cnt),
    .done_o  (wait_done)
  );

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_q     <= PMRSC_ST_ACTIVE;
      timers_on_q <= 1'b0;
      short_ok_q  <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        PMRSC_ST_ACTIVE:
        begin
          if (pd_ret_req)
          begin
            state_q     <= PMRSC_ST_RETAIN;
            timers_on_q <= lf_sel_q != PMRSC_LF_NONE;
            // oscillator field is sampled only at entry
            short_ok_q  <= xosc_run_q
                           && (clock_control_reg_q[PMRSC_CC_OSC_LO +: 2] == PMRSC_OSC_RC_ONLY
                               || clock_control_reg_q[PMRSC_CC_KEEP_XOSC]);
          end
          else if (pd_sby_req)
            state_q <= PMRSC_ST_STANDBY;
        end
        PMRSC_ST_STANDBY:
        begin
          if (sby_wake)
            state_q <= PMRSC_ST_WAKE;
        end
        PMRSC_ST_RETAIN:
        begin
          if (ret_wake)
            state_q <= PMRSC_ST_WAKE;
        end
        PMRSC_ST_WAKE:
        begin
          // cpu clock returns only once supplies are up, so no instruction is lost
          if (wait_done)
            state_q <= PMRSC_ST_ACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wake flags: set on retention wake, cleared by read or power-down entry
  // ----------------------------------------------------------------
  logic       pd_read;
  logic [2:0] wake_set;

  assign pd_read  = rd_acc && idx == PMRSC_IDX_POWER_DOWN_REG;
  assign wake_set = {ret_pin, ret_tick, ret_comp};

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      wake_flags_q <= 3'h0;
    else if (pd_read || pd_ret_req || pd_sby_req)
      wake_flags_q <= wake_set;
    else
      wake_flags_q <= wake_flags_q | wake_set;
  end

  // ----------------------------------------------------------------
  // interrupt status: write one to clear, set wins over clear
  // ----------------------------------------------------------------
  logic [3:0] ev;
  logic       xosc_rise;

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      xosc_run_q <= 1'b0;
    else
      xosc_run_q <= CRYSTAL_OSC_16M_RUN_I;
  end

  assign xosc_rise = CRYSTAL_OSC_16M_RUN_I && !xosc_run_q
                     && clock_control_reg_q[PMRSC_CC_XOSC_IRQEN];

  always_comb
  begin
    ev                    = 4'h0;
    ev[PMRSC_EV_RET_WAKE] = ret_wake;
    ev[PMRSC_EV_SBY_WAKE] = sby_wake;
    ev[PMRSC_EV_XOSC_UP]  = xosc_rise;
    ev[PMRSC_EV_PD_ENTER] = pd_ret_req || pd_sby_req;
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      irq_stat_q <= PMRSC_IRQ_RST;
    else if (wr_acc && idx == PMRSC_IDX_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~DAT_I[3:0]) | ev;
    else
      irq_stat_q <= irq_stat_q | ev;
  end

  assign IRQ_O = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // bus answer: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  logic [7:0] rd_d;

  always_comb
  begin
    rd_d = 8'h00;
    unique case (idx)
      PMRSC_IDX_CLOCK_CONTROL_REG:  rd_d = clock_control_reg_q;
      PMRSC_IDX_POWER_DOWN_REG:   rd_d = {wake_flags_q, 5'h00};
      PMRSC_IDX_LFSEL:    rd_d = {LOW_FREQ_CLOCK_I, LOW_FREQ_CLOCK_RDY_I, 2'h0,
                                  xosc_run_q, lf_sel_q};
      PMRSC_IDX_IRQ_STAT: rd_d = {4'h0, irq_stat_q};
      PMRSC_IDX_IRQ_MASK: rd_d = {4'h0, irq_mask_q};
      PMRSC_IDX_MODE:     rd_d = {5'h00, timers_on_q, state_q};
      default:            rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end
    else
    begin
      ACK_O <= req;
      if (rd_acc)
        DAT_O <= {24'h00_0000, rd_d};
    end
  end

  // ----------------------------------------------------------------
  // power and clock outputs
  // ----------------------------------------------------------------
  logic is_act;
  logic is_sby;
  logic is_ret;
  logic xo_field;
  logic rc_field;

  assign is_act   = state_q == PMRSC_ST_ACTIVE;
  assign is_sby   = state_q == PMRSC_ST_STANDBY;
  assign is_ret   = state_q == PMRSC_ST_RETAIN;
  assign xo_field = clock_control_reg_q[PMRSC_CC_OSC_LO +: 2] != PMRSC_OSC_RC_ONLY;
  assign rc_field = clock_control_reg_q[PMRSC_CC_OSC_LO +: 2] != PMRSC_OSC_XO_ONLY;

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      CPU_CLK_EN_O           <= 1'b1;
      SYS_RESET_O            <= 1'b0;
      PROG_MEM_PWR_O         <= 1'b1;
      DATA_MEM_PWR_O         <= 1'b1;
      VOLTAGE_REGULATOR_EN_O <= 1'b1;
      CRYSTAL_OSC_16M_EN_O   <= 1'b1;
      RC_OSC_16M_A_EN_O      <= 1'b1;
      LF_TIMERS_EN_O         <= 1'b1;
      IO_ACTIVE_O            <= 1'b1;
      MODE_O                 <= 2'b00;
    end
    else
    begin
      CPU_CLK_EN_O           <= is_act;
      SYS_RESET_O            <= 1'b0;
      PROG_MEM_PWR_O         <= !is_ret;
      DATA_MEM_PWR_O         <= !is_ret;
      // pre-start brings the regulator up during the wake wait
      VOLTAGE_REGULATOR_EN_O <= !is_ret;
      CRYSTAL_OSC_16M_EN_O   <= is_sby
                                || (is_ret && clock_control_reg_q[PMRSC_CC_KEEP_XOSC])
                                || (!is_sby && !is_ret && xo_field);
      RC_OSC_16M_A_EN_O      <= !is_sby && !is_ret && rc_field;
      LF_TIMERS_EN_O         <= !is_ret || timers_on_q;
      IO_ACTIVE_O            <= !is_ret;
      MODE_O                 <= state_q;
    end
  end

endmodule : pmrsc_ctrl
`default_nettype wire

// ### rtl/pmrsc_pkg.sv
// pmrsc_pkg: register map, field layout, reset values and timing of the power-mode controller
package pmrsc_pkg;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0] PMRSC_IDX_CLOCK_CONTROL_REG  = 10'h0A3;
  localparam logic [9:0] PMRSC_IDX_POWER_DOWN_REG   = 10'h0A4;
  localparam logic [9:0] PMRSC_IDX_LFSEL    = 10'h0AD;
  localparam logic [9:0] PMRSC_IDX_IRQ_STAT = 10'h0B0;
  localparam logic [9:0] PMRSC_IDX_IRQ_MASK = 10'h0B1;
  localparam logic [9:0] PMRSC_IDX_MODE     = 10'h0B2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PMRSC_CLOCK_CONTROL_REG_RST = 8'h00;
  localparam logic [2:0] PMRSC_LFSEL_RST   = 3'h2;
  localparam logic [3:0] PMRSC_IRQ_RST     = 4'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PMRSC_CC_KEEP_XOSC  = 7;
  localparam int PMRSC_CC_OSC_LO     = 4;
  localparam int PMRSC_CC_XOSC_IRQEN = 3;
  localparam int PMRSC_LF_PHASE      = 7;
  localparam int PMRSC_LF_READY      = 6;
  localparam int PMRSC_LF_XOSC_ACT   = 3;
  localparam int PMRSC_PD_PIN        = 7;
  localparam int PMRSC_PD_TICK       = 6;
  localparam int PMRSC_PD_COMP       = 5;

  // oscillator start field codes
  localparam logic [1:0] PMRSC_OSC_BOTH    = 2'h0;
  localparam logic [1:0] PMRSC_OSC_RC_ONLY = 2'h1;
  localparam logic [1:0] PMRSC_OSC_XO_ONLY = 2'h2;

  // power-down codes and the "no low-frequency source" code
  localparam logic [2:0] PMRSC_PD_REG_RET = 3'h4;
  localparam logic [2:0] PMRSC_PD_STANDBY = 3'h7;
  localparam logic [2:0] PMRSC_LF_NONE    = 3'h7;

  // interrupt status bit positions
  localparam int PMRSC_EV_RET_WAKE = 0;
  localparam int PMRSC_EV_SBY_WAKE = 1;
  localparam int PMRSC_EV_XOSC_UP  = 2;
  localparam int PMRSC_EV_PD_ENTER = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PMRSC_CLK_PERIOD_PS   = 8000;
  localparam int PMRSC_SBY_WAKE_NS     = 100;
  localparam int PMRSC_SBY_WAKE_CYC    = (PMRSC_SBY_WAKE_NS * 1000 / PMRSC_CLK_PERIOD_PS < 1) ? 1
                                       : PMRSC_SBY_WAKE_NS * 1000 / PMRSC_CLK_PERIOD_PS;
  localparam int PMRSC_LONG_PRE_US     = 100;
  localparam int PMRSC_LONG_PRE_CYC    = PMRSC_LONG_PRE_US * 1000000 / PMRSC_CLK_PERIOD_PS;
  localparam int PMRSC_SHORT_PRE_CYC   = 4;
  localparam int PMRSC_CNT_W           = 16;

  typedef enum logic [1:0] {
    PMRSC_ST_ACTIVE  = 2'b00,
    PMRSC_ST_STANDBY = 2'b01,
    PMRSC_ST_RETAIN  = 2'b10,
    PMRSC_ST_WAKE    = 2'b11
  } pmrsc_state_t;

endpackage : pmrsc_pkg

// ### rtl/pmrsc_wait.sv
// pmrsc_wait: load-and-count-down delay used for wakeup start-up times
`timescale 1ns/10ps
`default_nettype none
module pmrsc_wait
  import pmrsc_pkg::*;
#(
  parameter int W = PMRSC_CNT_W
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);

  logic [W-1:0] cnt_q;
  logic         run_q;

  // done pulses once when the loaded count has fully elapsed
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_o <= 1'b0;
    end
    else if (load_i)
    begin
      cnt_q  <= count_i;
      run_q  <= 1'b1;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= run_q && (cnt_q <= W'(1));
      if (run_q)
      begin
        cnt_q <= (cnt_q == '0) ? '0 : cnt_q - W'(1);
        run_q <= (cnt_q > W'(1));
      end
    end
  end

endmodule : pmrsc_wait
`default_nettype wire

// ### tb/pmrsc_ctrl_monitor.sv
// pmrsc_ctrl_monitor: port-level assertions for the power-mode controller
`timescale 1ns/10ps
`default_nettype none
module pmrsc_ctrl_monitor
  import pmrsc_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        RST_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [11:0] ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic        ACK_O,
  input wire logic        WAKE_PIN_I,
  input wire logic        TIMER_TICK_I,
  input wire logic        COMP_WAKE_I,
  input wire logic        RADIO_IRQ_I,
  input wire logic        MISC_IRQ_B_I,
  input wire logic        CPU_CLK_EN_O,
  input wire logic        SYS_RESET_O,
  input wire logic        PROG_MEM_PWR_O,
  input wire logic        DATA_MEM_PWR_O,
  input wire logic        VOLTAGE_REGULATOR_EN_O,
  input wire logic        CRYSTAL_OSC_16M_EN_O,
  input wire logic        LF_TIMERS_EN_O,
  input wire logic        IO_ACTIVE_O,
  input wire logic [1:0]  MODE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  // ----------------------------------------------------------------
  // bus, mode entry and wakeup
  // ----------------------------------------------------------------
  a_ack_single_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acknowledged next cycle");
  a_ret_entry: assert property (CYC_I && STB_I && WE_I && !ACK_O && SEL_I[0]
    && ADR_I[11:2] == PMRSC_IDX_POWER_DOWN_REG && DAT_I[2:0] == PMRSC_PD_REG_RET
    && MODE_O == 2'h0 |-> ##[1:2] MODE_O == 2'h2) else $error("retention not entered");
  a_no_sys_reset: assert property (!SYS_RESET_O)
    else $error("system reset raised");
  a_sby_cpu_stop: assert property (MODE_O == 2'h1 |-> !CPU_CLK_EN_O && IO_ACTIVE_O)
    else $error("standby cpu clock or io wrong");
  a_sby_powered: assert property (MODE_O == 2'h1 |-> PROG_MEM_PWR_O
    && DATA_MEM_PWR_O && VOLTAGE_REGULATOR_EN_O && CRYSTAL_OSC_16M_EN_O)
    else $error("standby power lost");
  a_active_all_on: assert property (MODE_O == 2'h0 |-> CPU_CLK_EN_O
    && PROG_MEM_PWR_O && DATA_MEM_PWR_O && VOLTAGE_REGULATOR_EN_O && IO_ACTIVE_O)
    else $error("active mode not fully powered");
  a_sby_comp_ignored: assert property (MODE_O == 2'h1 && COMP_WAKE_I && !WAKE_PIN_I
    && !TIMER_TICK_I && !RADIO_IRQ_I && !MISC_IRQ_B_I |=> MODE_O == 2'h1)
    else $error("comparator woke standby");
  a_sby_irq_wake: assert property (MODE_O == 2'h1 && (RADIO_IRQ_I || MISC_IRQ_B_I)
    |-> ##[1:2] MODE_O == 2'h3 ##[1:20] MODE_O == 2'h0)
    else $error("standby interrupt wake too slow");
  a_ret_pin_wake: assert property (MODE_O == 2'h2 && WAKE_PIN_I
    |-> ##[1:2] MODE_O == 2'h3) else $error("pin did not wake retention");
  a_tick_timers_off: assert property (MODE_O == 2'h2 && !LF_TIMERS_EN_O
    && TIMER_TICK_I && !WAKE_PIN_I |=> MODE_O == 2'h2) else $error("tick woke timers-off");
endmodule : pmrsc_ctrl_monitor
`default_nettype wire

// ### tb/pmrsc_ctrl_tb_top.sv
// pmrsc_ctrl_tb_top: directed register-level bench for the power-mode controller
`timescale 1ns/10ps
`default_nettype none
module pmrsc_ctrl_tb_top
  import pmrsc_pkg::*;
;
  localparam int LONG = 20;
  logic        clk, rst, cyc, stb, we, xrun, lfrdy, ack, irq, cpu, sysrst, lfen, rcen;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] dat, dout, rd;
  logic [4:0]  wk;
  logic [1:0]  mode;
  int          fail_count, checks_done, n, i;
  // pre-start table: clock control value, crystal running, short expected
  logic [7:0]  ccv [4] = '{8'h10, 8'h10, 8'h80, 8'h00};
  logic [3:0]  xrv = 4'hD;
  logic [3:0]  shv = 4'h5;

  pmrsc_ctrl #(.LONG_PRE_CYC(LONG)) DUT (.CORE_CLK_I(clk), .RST_I(rst), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dout),
    .ACK_O(ack), .WAKE_PIN_I(wk[0]), .TIMER_TICK_I(wk[1]), .COMP_WAKE_I(wk[2]),
    .RADIO_IRQ_I(wk[3]), .MISC_IRQ_B_I(wk[4]), .CRYSTAL_OSC_16M_RUN_I(xrun),
    .LOW_FREQ_CLOCK_I(1'h0), .LOW_FREQ_CLOCK_RDY_I(lfrdy), .CPU_CLK_EN_O(cpu),
    .SYS_RESET_O(sysrst), .PROG_MEM_PWR_O(), .DATA_MEM_PWR_O(), .VOLTAGE_REGULATOR_EN_O(),
    .CRYSTAL_OSC_16M_EN_O(), .RC_OSC_16M_A_EN_O(rcen), .LF_TIMERS_EN_O(lfen), .IO_ACTIVE_O(),
    .MODE_O(mode), .IRQ_O(irq));

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic hang(input string nm);
    fail_count++;
    $display("BAD %s timed out", nm);
    give_verdict();
  endtask : hang

  // ----------------------------------------------------------------
  // bus cycle, wake pulse, mode wait
  // ----------------------------------------------------------------
  // request held until the rising edge that samples ack high; data taken there
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we  <= w;
    adr <= {a, 2'h0};
    dat <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 8)
        hang("ack");
    end
    while (ack !== 1'h1);
    rd = dout;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb

  task automatic pulse(input int k);
    @(posedge clk);
    wk <= 5'h01 << k;
    @(posedge clk);
    wk <= 5'h00;
  endtask : pulse

  task automatic wait_mode(input logic [1:0] m, input int lim);
    n = 0;
    while (mode !== m)
    begin
      @(negedge clk);
      n++;
      if (n > lim)
        hang("mode");
    end
  endtask : wait_mode

  initial
  begin
    rst = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 12'h000;
    sel = 4'hF;
    dat = 32'h0;
    wk = 5'h00;
    xrun = 1'h1;
    lfrdy = 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    wb(0, PMRSC_IDX_CLOCK_CONTROL_REG, 8'h00);
    chk("clock_control_reg", rd, 32'h0);
    wb(0, PMRSC_IDX_LFSEL, 8'h00);
    chk("lfsel", rd, 32'h4A);
    @(posedge clk);
    xrun <= 1'h0;
    wb(0, PMRSC_IDX_LFSEL, 8'h00);
    chk("lfsel", rd, 32'h42);
    wb(0, PMRSC_IDX_MODE, 8'h00);
    chk("mode_reg", rd, 32'h0);
    chk("rc_osc", rcen, 1'h1);
    wb(0, 10'h0C0, 8'h00);
    chk("unmapped", rd, 32'h0);
    $display("test registers done");
    wb(1, PMRSC_IDX_IRQ_MASK, 8'h03);
    for (i = 3; i < 5; i++)
    begin
      wb(1, PMRSC_IDX_POWER_DOWN_REG, 8'h07);
      wait_mode(2'h1, 4);
      chk("cpu_clk", cpu, 1'h0);
      pulse(2);
      repeat (3) @(negedge clk);
      chk("sby_comp", mode, 2'h1);
      pulse(i);
      wait_mode(2'h0, 20);
      chk("cpu_clk", cpu, 1'h1);
      chk("irq", irq, 1'h1);
      wb(1, PMRSC_IDX_IRQ_STAT, 8'h0F);
      chk("irq", irq, 1'h0);
    end
    $display("test standby done");
    wb(1, PMRSC_IDX_POWER_DOWN_REG, 8'h01);
    chk("bad_code", mode, 2'h0);
    wb(1, PMRSC_IDX_LFSEL, 8'h07);
    wb(0, PMRSC_IDX_MODE, 8'h00);
    chk("mode_reg", rd, 32'h0);
    wb(1, PMRSC_IDX_POWER_DOWN_REG, 8'h04);
    wait_mode(2'h2, 4);
    chk("lf_timers", lfen, 1'h0);
    wb(0, PMRSC_IDX_MODE, 8'h00);
    chk("mode_ret", rd, 32'h2);
    pulse(1);
    repeat (3) @(negedge clk);
    chk("tick_off", mode, 2'h2);
    pulse(0);
    wait_mode(2'h0, LONG + 10);
    chk("sys_reset", sysrst, 1'h0);
    chk("irq", irq, 1'h1);
    wb(1, PMRSC_IDX_IRQ_MASK, 8'h00);
    chk("irq_masked", irq, 1'h0);
    wb(1, PMRSC_IDX_IRQ_MASK, 8'h03);
    chk("irq", irq, 1'h1);
    wb(1, PMRSC_IDX_IRQ_STAT, 8'h0F);
    chk("irq_clr", irq, 1'h0);
    wb(0, PMRSC_IDX_POWER_DOWN_REG, 8'h00);
    chk("wake_src", rd, 32'h80);
    wb(0, PMRSC_IDX_POWER_DOWN_REG, 8'h00);
    chk("wake_src", rd, 32'h0);
    $display("test timers-off done");
    wb(1, PMRSC_IDX_LFSEL, 8'h02);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      xrun <= xrv[i];
      wb(1, PMRSC_IDX_CLOCK_CONTROL_REG, ccv[i]);
      wb(1, PMRSC_IDX_POWER_DOWN_REG, 8'h04);
      wait_mode(2'h2, 4);
      pulse(1);
      wait_mode(2'h0, LONG + 10);
      chk("prestart", n < 15, shv[i]);
      wb(0, PMRSC_IDX_POWER_DOWN_REG, 8'h00);
      chk("wake_src", rd, 32'h40);
    end
    wb(1, PMRSC_IDX_POWER_DOWN_REG, 8'h04);
    wait_mode(2'h2, 4);
    wb(0, PMRSC_IDX_MODE, 8'h00);
    chk("mode_ret", rd, 32'h6);
    pulse(2);
    wait_mode(2'h0, LONG + 10);
    wb(0, PMRSC_IDX_POWER_DOWN_REG, 8'h00);
    chk("wake_src", rd, 32'h20);
    $display("test timers-on done");
    give_verdict();
  end
endmodule : pmrsc_ctrl_tb_top

bind pmrsc_ctrl pmrsc_ctrl_monitor u_mon (.CORE_CLK_I, .RST_I, .CYC_I, .STB_I, .WE_I,
  .ADR_I, .SEL_I, .DAT_I, .ACK_O, .WAKE_PIN_I, .TIMER_TICK_I, .COMP_WAKE_I, .RADIO_IRQ_I,
  .MISC_IRQ_B_I, .CPU_CLK_EN_O, .SYS_RESET_O, .PROG_MEM_PWR_O, .DATA_MEM_PWR_O,
  .VOLTAGE_REGULATOR_EN_O, .CRYSTAL_OSC_16M_EN_O, .LF_TIMERS_EN_O, .IO_ACTIVE_O, .MODE_O);
`default_nettype wire
